/* File: core/strap_cfg_pkg.sv */
// Constants and types for strap configuration and reference selection
package strap_cfg_pkg;

    // ********************************
    // Timing
    // ********************************
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int STEP_SETTLE_NS  = 100;
    localparam int SETTLE_CYC      = (STEP_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam logic [4:0] SETTLE_LAST = 5'(SETTLE_CYC - 1);

    // ********************************
    // Probe sequence
    // ********************************
    localparam int         PROBE_STEPS = 3;
    localparam logic [1:0] STEP_FIRST  = 2'h0;
    localparam logic [1:0] STEP_LAST   = 2'(PROBE_STEPS - 1);
    // Config output drive per step, bit k = config output k (bit 3 is the alarm pin)
    localparam logic [3:0] DRIVE_STEP0 = 4'h9;
    localparam logic [3:0] DRIVE_STEP1 = 4'hA;
    localparam logic [3:0] DRIVE_STEP2 = 4'h4;
    localparam logic [3:0] DRIVE_IDLE  = 4'h0;

    // Sampled strap patterns, bit s = level seen at step s
    localparam logic [2:0] PAT_LOW  = 3'h0;
    localparam logic [2:0] PAT_HIGH = 3'h7;
    localparam logic [2:0] PAT_OUT0 = 3'h1;
    localparam logic [2:0] PAT_OUT1 = 3'h2;
    localparam logic [2:0] PAT_OUT2 = 3'h4;
    localparam logic [2:0] PAT_CLOCK_OUTPUT_C = 3'h3;

    // ********************************
    // Strap classes
    // ********************************
    localparam logic [2:0] CLS_GROUND = 3'h0;
    localparam logic [2:0] CLS_SUPPLY = 3'h1;
    localparam logic [2:0] CLS_OUT0   = 3'h2;
    localparam logic [2:0] CLS_OUT1   = 3'h3;
    localparam logic [2:0] CLS_OUT2   = 3'h4;
    localparam logic [2:0] CLS_CLOCK_OUTPUT_C   = 3'h5;
    localparam logic [5:0] NUM_CLASSES = 6'h6;

    // ********************************
    // Joint decode fields of the strap pair index
    // ********************************
    localparam int DIV_SEL_LSB  = 0;
    localparam int DIV_SEL_MSB  = 2;
    localparam int LOCK_DIS_BIT = 3;
    localparam int PAD_ECL_BIT  = 4;

    // ********************************
    // Reset values of the latched configuration
    // ********************************
    localparam logic [3:0] ODD_DIV_RESET = 4'h1;

    typedef enum logic [0:0] {CFG_PROBE, CFG_DONE} cfg_state_e;

endpackage : strap_cfg_pkg

/* File: core/strap_config_and_ref_select.sv */
// Strap probing, configuration latch and reference selection
//
// Overview of operation
// - After reset each of the two straps is classed as ground, supply or tied to one of four config outputs.
// - The strap pair jointly picks an odd output divider of 1 to 15 for all four clock outputs.
// - The strap pair also enables or disables the lock indicator.
// - The strap pair also picks CML or ECL pads for clock outputs c and d.
// - In manual mode the high select level picks reference b and the low level picks reference a.
// - A high auto select level puts the device into automatic reference switching, whatever the manual select level.
// - With the lock indicator disabled by strap the lock output stays low.
// - Once the configuration is latched, the alarm output is high while the selected reference has failed and low otherwise.
`timescale 1ns/100ps
module strap_config_and_ref_select
    import strap_cfg_pkg::*;
(
    input  wire logic       clock,               // 125 MHz system clock
    input  wire logic       rstn,                // Power-on reset, active low
    input  wire logic       strap_input_g,       // Strap pin g
    input  wire logic       strap_input_h,       // Strap pin h
    input  wire logic       manual_ref_select,   // High picks ref b in manual mode
    input  wire logic       auto_select,         // High requests automatic switching
    input  wire logic       ref_a_failed,        // Activity monitor, ref a failed
    input  wire logic       ref_b_failed,        // Activity monitor, ref b failed
    input  wire logic       lock_raw,            // Raw lock detector level
    output logic [2:0]      config_out,          // Config outputs 0..2
    output logic            selected_ref_alarm,  // Alarm, doubles as config output 3
    output logic            lock_indicator,      // Gated lock indicator
    output logic            config_valid,        // Configuration latched
    output logic [3:0]      odd_divider,         // Odd divider value 1..15
    output logic            lock_enable,         // Lock indicator enabled
    output logic            pad_mode_ecl,        // Outputs c and d: 1 ECL, 0 CML
    output logic            auto_mode,           // Automatic switching active
    output logic            ref_select_b         // Selected reference: 1 b, 0 a
);

    // ********************************
    // Functions
    // ********************************
    function automatic logic [3:0] drive_for_step(input logic [1:0] step);
        logic [3:0] d;
        d = DRIVE_IDLE;
        case (step)
            2'h0:    d = DRIVE_STEP0;
            2'h1:    d = DRIVE_STEP1;
            2'h2:    d = DRIVE_STEP2;
            default: d = DRIVE_IDLE;
        endcase
        return d;
    endfunction : drive_for_step

    function automatic logic [2:0] classify(input logic [2:0] pat);
        logic [2:0] c;
        c = CLS_GROUND;
        if (pat == PAT_HIGH)      c = CLS_SUPPLY;
        else if (pat == PAT_OUT0) c = CLS_OUT0;
        else if (pat == PAT_OUT1) c = CLS_OUT1;
        else if (pat == PAT_OUT2) c = CLS_OUT2;
        else if (pat == PAT_CLOCK_OUTPUT_C) c = CLS_CLOCK_OUTPUT_C;
        else                      c = CLS_GROUND;  // Odd patterns treated as ground
        return c;
    endfunction : classify

    // ********************************
    // Input synchronisers
    // ********************************
    logic [6:0] sync1_reg;
    logic [6:0] sync2_reg;
    logic [6:0] pins_in;
    assign pins_in = {lock_raw, ref_b_failed, ref_a_failed, auto_select,
                      manual_ref_select, strap_input_h, strap_input_g};

    always_ff @(posedge clock) begin
        if (!rstn) begin
            sync1_reg <= 7'h00;
            sync2_reg <= 7'h00;
        end else begin
            sync1_reg <= pins_in;
            sync2_reg <= sync1_reg;
        end
    end

    wire g_s      = sync2_reg[0];
    wire h_s      = sync2_reg[1];
    wire man_s    = sync2_reg[2];
    wire auto_s   = sync2_reg[3];
    wire a_fail_s = sync2_reg[4];
    wire b_fail_s = sync2_reg[5];
    wire lock_s   = sync2_reg[6];

    // ********************************
    // Strap probing
    // ********************************
    cfg_state_e  state_reg, state_next;
    logic [4:0]  settle_reg, settle_next;
    logic [1:0]  step_reg, step_next;
    logic [2:0]  g_bits_reg, g_bits_next;
    logic [2:0]  h_bits_reg, h_bits_next;
    logic [3:0]  drive_reg, drive_next;

    wire probing   = (state_reg == CFG_PROBE);
    wire sample_now = probing && (settle_reg == SETTLE_LAST);
    wire last_step  = (step_reg == STEP_LAST);
    wire finish     = sample_now && last_step;

    // Settle covers the sync delay plus board slew before each sample
    always_comb begin
        state_next  = state_reg;
        settle_next = settle_reg;
        step_next   = step_reg;
        g_bits_next = g_bits_reg;
        h_bits_next = h_bits_reg;
        drive_next  = drive_reg;
        case (state_reg)
            CFG_PROBE: begin
                settle_next = settle_reg + 5'h01;
                if (sample_now) begin
                    settle_next           = 5'h00;
                    g_bits_next[step_reg] = g_s;
                    h_bits_next[step_reg] = h_s;
                    if (last_step) begin
                        state_next = CFG_DONE;
                        drive_next = DRIVE_IDLE;
                    end else begin
                        step_next  = step_reg + 2'h1;
                        drive_next = drive_for_step(step_reg + 2'h1);
                    end
                end
            end
            default: begin
                state_next = CFG_DONE;
            end
        endcase
    end

    // Release of reset restarts probing from the first step
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_reg  <= CFG_PROBE;
            settle_reg <= 5'h00;
            step_reg   <= STEP_FIRST;
            g_bits_reg <= PAT_LOW;
            h_bits_reg <= PAT_LOW;
            drive_reg  <= DRIVE_STEP0;
        end else begin
            state_reg  <= state_next;
            settle_reg <= settle_next;
            step_reg   <= step_next;
            g_bits_reg <= g_bits_next;
            h_bits_reg <= h_bits_next;
            drive_reg  <= drive_next;
        end
    end

    // ********************************
    // Joint decode and latch
    // ********************************
    logic [2:0] g_cls, h_cls;
    logic [5:0] pair_index;
    logic [2:0] div_sel;
    assign g_cls      = classify(g_bits_next);
    assign h_cls      = classify(h_bits_next);
    assign pair_index = 6'(g_cls) * NUM_CLASSES + 6'(h_cls);
    assign div_sel    = pair_index[DIV_SEL_MSB:DIV_SEL_LSB];

    logic [3:0] odd_div_reg;
    logic       lock_en_reg;
    logic       pad_ecl_reg;
    logic       valid_reg;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            odd_div_reg <= ODD_DIV_RESET;
            lock_en_reg <= 1'b0;
            pad_ecl_reg <= 1'b0;
            valid_reg   <= 1'b0;
        end else if (finish) begin
            odd_div_reg <= {div_sel, 1'b1};
            lock_en_reg <= ~pair_index[LOCK_DIS_BIT];
            pad_ecl_reg <= pair_index[PAD_ECL_BIT];
            valid_reg   <= 1'b1;
        end
    end

    // ********************************
    // Reference selection
    // ********************************
    logic sel_b_reg, sel_b_next;
    logic auto_reg;
    logic alarm_reg, alarm_next;
    logic lock_reg;

    wire  sel_fail = sel_b_reg ? b_fail_s : a_fail_s;
    wire  alt_fail = sel_b_reg ? a_fail_s : b_fail_s;

    // Auto mode keeps the current reference until it fails and the other is good
    always_comb begin
        sel_b_next = sel_b_reg;
        if (!auto_s)
            sel_b_next = man_s;
        else if (sel_fail && !alt_fail)
            sel_b_next = ~sel_b_reg;
    end

    // Alarm pin carries the probe pattern until the configuration is latched
    assign alarm_next = probing ? drive_next[3] : (sel_b_next ? b_fail_s : a_fail_s);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            sel_b_reg <= 1'b0;
            auto_reg  <= 1'b0;
            alarm_reg <= DRIVE_STEP0[3];
            lock_reg  <= 1'b0;
        end else begin
            sel_b_reg <= sel_b_next;
            auto_reg  <= auto_s;
            alarm_reg <= alarm_next;
            lock_reg  <= lock_s && lock_en_reg && valid_reg;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign config_out         = drive_reg[2:0];
    assign selected_ref_alarm = alarm_reg;
    assign lock_indicator     = lock_reg;
    assign config_valid       = valid_reg;
    assign odd_divider        = odd_div_reg;
    assign lock_enable        = lock_en_reg;
    assign pad_mode_ecl       = pad_ecl_reg;
    assign auto_mode          = auto_reg;
    assign ref_select_b       = sel_b_reg;

    // ********************************
    // Assertions
    // ********************************
    property p_probe_drive;
        @(posedge clock) disable iff (!rstn)
        (probing && step_reg == STEP_FIRST) |-> (drive_reg == DRIVE_STEP0);
    endproperty
    a_probe_drive: assert property (p_probe_drive) else $error("probe drive wrong at step 0");

    property p_odd_div;
        @(posedge clock) disable iff (!rstn)
        valid_reg |-> odd_div_reg[0];
    endproperty
    a_odd_div: assert property (p_odd_div) else $error("divider not odd");

    property p_lock_en_decode;
        @(posedge clock) disable iff (!rstn)
        finish |=> (lock_en_reg == ~$past(pair_index[LOCK_DIS_BIT]));
    endproperty
    a_lock_en_decode: assert property (p_lock_en_decode) else $error("lock enable decode wrong");

    property p_pad_decode;
        @(posedge clock) disable iff (!rstn)
        finish |=> (pad_ecl_reg == $past(pair_index[PAD_ECL_BIT]));
    endproperty
    a_pad_decode: assert property (p_pad_decode) else $error("pad mode decode wrong");

    property p_manual_sel;
        @(posedge clock) disable iff (!rstn)
        (!auto_s) |=> (sel_b_reg == $past(man_s));
    endproperty
    a_manual_sel: assert property (p_manual_sel) else $error("manual select not followed");

    property p_auto_switch;
        @(posedge clock) disable iff (!rstn)
        (auto_s && sel_fail && !alt_fail) |=> (sel_b_reg != $past(sel_b_reg));
    endproperty
    a_auto_switch: assert property (p_auto_switch) else $error("auto switch did not occur");

    property p_lock_low;
        @(posedge clock) disable iff (!rstn)
        (valid_reg && !lock_en_reg) ##1 (valid_reg && !lock_en_reg) |-> !lock_indicator;
    endproperty
    a_lock_low: assert property (p_lock_low) else $error("lock output high while disabled");

    property p_alarm;
        @(posedge clock) disable iff (!rstn)
        (!probing) |=> (selected_ref_alarm == (sel_b_reg ? $past(b_fail_s) : $past(a_fail_s)));
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm does not follow selected reference");

    property p_cfg_hold;
        @(posedge clock) disable iff (!rstn)
        (valid_reg && $past(valid_reg)) |-> ($stable(odd_div_reg) && $stable(lock_en_reg) && $stable(pad_ecl_reg));
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("latched configuration changed");

endmodule : strap_config_and_ref_select

/* File: bench/strap_board.sv */
// Board model: strap wiring and reference health levels
`timescale 1ns/100ps
module strap_board (
    input  wire logic [2:0] cls_g,          // Wiring class of strap g
    input  wire logic [2:0] cls_h,          // Wiring class of strap h
    input  wire logic [2:0] config_out,     // Device config outputs 0..2
    input  wire logic       alarm_pin,      // Device config output 3
    input  wire logic       fail_a_cmd,     // Commanded fault of ref a
    input  wire logic       fail_b_cmd,     // Commanded fault of ref b
    output logic            strap_input_g,  // Strap pin g level
    output logic            strap_input_h,  // Strap pin h level
    output logic            ref_a_failed,   // Monitor level of ref a
    output logic            ref_b_failed    // Monitor level of ref b
);
    // ********************************
    // Strap wiring
    // ********************************
    // Class 0 ground, 1 supply, 2..5 tied to config outputs 0..3
    wire logic [5:0] levels;
    assign levels        = {alarm_pin, config_out, 1'b1, 1'b0};
    assign strap_input_g = levels[cls_g];
    assign strap_input_h = levels[cls_h];

    // ********************************
    // Reference sources
    // ********************************
    // Sources stay in range unless a scenario commands a fault
    assign ref_a_failed = fail_a_cmd;
    assign ref_b_failed = fail_b_cmd;
endmodule : strap_board

/* File: bench/tb_top.sv */
// Testbench for strap configuration and reference selection
`timescale 1ns/100ps
module tb_top;
    import strap_cfg_pkg::*;
    localparam int CYCLE_LIMIT = 6000;
    logic       clock, rstn, manual_ref_select, auto_select, lock_raw, fail_a, fail_b, cv_seen;
    logic [2:0] cls_g, cls_h, config_out;
    logic [3:0] odd_divider;
    logic [5:0] exp_note, n;
    logic [31:0] seed, r;
    logic       strap_input_g, strap_input_h, ref_a_failed, ref_b_failed;
    logic       selected_ref_alarm, lock_indicator, config_valid, lock_enable, pad_mode_ecl;
    logic       auto_mode, ref_select_b;
    logic [5:0] note_q[$];
    int         mismatches, n_compared, cycles;

    strap_config_and_ref_select dut_u (.clock(clock), .rstn(rstn), .strap_input_g(strap_input_g),
        .strap_input_h(strap_input_h), .manual_ref_select(manual_ref_select), .auto_select(auto_select),
        .ref_a_failed(ref_a_failed), .ref_b_failed(ref_b_failed), .lock_raw(lock_raw),
        .config_out(config_out), .selected_ref_alarm(selected_ref_alarm), .lock_indicator(lock_indicator),
        .config_valid(config_valid), .odd_divider(odd_divider), .lock_enable(lock_enable),
        .pad_mode_ecl(pad_mode_ecl), .auto_mode(auto_mode), .ref_select_b(ref_select_b));

    strap_board board_u (.cls_g(cls_g), .cls_h(cls_h), .config_out(config_out),
        .alarm_pin(selected_ref_alarm), .fail_a_cmd(fail_a), .fail_b_cmd(fail_b),
        .strap_input_g(strap_input_g), .strap_input_h(strap_input_h),
        .ref_a_failed(ref_a_failed), .ref_b_failed(ref_b_failed));

    // ********************************
    // Helpers
    // ********************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Expected {pad, lock enable, divider} for a strap pair
    function automatic logic [5:0] note_for(input int g, input int h);
        int idx;
        idx = g * 6 + h;
        return {idx[4], ~idx[3], idx[2:0], 1'b1};
    endfunction : note_for

    task automatic check(input logic [7:0] seen, input logic [7:0] expd);
        n_compared++;
        if (seen !== expd) begin
            mismatches++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, expd);
        end
    endtask : check

    task automatic report_and_stop();
        if (mismatches == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    task automatic step(input int cnt);
        repeat (cnt) @(posedge clock);
        #1;
    endtask : step

    task automatic run_config(input int g, input int h);
        int k;
        cls_g = 3'(g);
        cls_h = 3'(h);
        rstn  = 1'b0;
        step(3);
        check({selected_ref_alarm, config_out}, 8'h09);
        note_q.push_back(note_for(g, h));
        rstn = 1'b1;
        k = 0;
        while (config_valid !== 1'b1 && k < 60) begin
            step(1);
            k++;
            if (k == 5) check({selected_ref_alarm, config_out}, 8'h09);
            if (k == 18) check({selected_ref_alarm, config_out}, 8'h0A);
            if (k == 31) check({selected_ref_alarm, config_out}, 8'h04);
        end
        check(k < 60, 8'h01);
        step(1);
        check({selected_ref_alarm, config_out}, 8'h00);
    endtask : run_config

    // ********************************
    // Clock, timeout, result watcher
    // ********************************
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == CYCLE_LIMIT) begin
            mismatches++;
            report_and_stop();
        end
    end

    // Latched configuration compared against the oldest note
    always @(negedge clock) begin
        if (config_valid === 1'b1 && cv_seen !== 1'b1) begin
            if (note_q.size() == 0) check(8'h00, 8'hFF);
            else begin
                exp_note = note_q.pop_front();
                check({pad_mode_ecl, lock_enable, odd_divider}, exp_note);
            end
        end
        cv_seen <= config_valid;
    end

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        {rstn, manual_ref_select, auto_select, lock_raw, fail_a, fail_b} = 6'h00;
        {cls_g, cls_h} = 6'h00;
        {mismatches, n_compared} = '0;
        seed = 32'h0000329E;
        for (int g = 0; g < 6; g++) begin
            for (int h = 0; h < 6; h++) begin
                run_config(g, h);
                n = note_for(g, h);
                r = xs();
                lock_raw = r[0];
                step(4);
                check(lock_indicator, r[0] & n[4]);
                cls_g = 3'(5 - g);
                cls_h = 3'(5 - h);
                step(20);
                check({pad_mode_ecl, lock_enable, odd_divider, config_valid}, {n, 1'b1});
            end
        end
        for (int i = 0; i < 16; i++) begin
            r = xs();
            {fail_b, fail_a, manual_ref_select} = r[2:0];
            step(4);
            check({auto_mode, ref_select_b}, {1'b0, r[0]});
            check(selected_ref_alarm, r[0] ? r[2] : r[1]);
        end
        {fail_b, fail_a, manual_ref_select} = 3'h0;
        step(4);
        auto_select = 1'b1;
        step(4);
        check({auto_mode, ref_select_b}, 8'h02);
        fail_a = 1'b1;
        manual_ref_select = 1'b0;
        step(4);
        check({ref_select_b, selected_ref_alarm}, 8'h02);
        fail_a = 1'b0;
        step(4);
        check(ref_select_b, 8'h01);
        fail_b = 1'b1;
        step(4);
        check({ref_select_b, selected_ref_alarm}, 8'h00);
        fail_a = 1'b1;
        manual_ref_select = 1'b1;
        step(4);
        check({ref_select_b, selected_ref_alarm}, 8'h01);
        report_and_stop();
    end
endmodule : tb_top
